// *** rtl/cbr_pkg.sv ***
// Constants, carriers and states shared by the clock buffer SMBus register bank
package cbr_pkg;
   // Target address and register indexes
   localparam logic [6:0] CBR_TARGET_ADDR = 7'h4b;  // Arbitrary value
   localparam logic [7:0] CBR_IDX_MODE    = 8'h00;
   localparam logic [7:0] CBR_IDX_GATE_LO = 8'h01;
   localparam logic [7:0] CBR_IDX_GATE_HI = 8'h02;
   localparam logic [7:0] CBR_IDX_SPARE_A = 8'h03;
   localparam logic [7:0] CBR_IDX_SPARE_B = 8'h04;
   localparam logic [7:0] CBR_IDX_IDENT   = 8'h05;
   localparam logic [7:0] CBR_IDX_PART    = 8'h06;
   localparam logic [7:0] CBR_IDX_COUNT   = 8'h07;
   localparam int         CBR_NUM_BYTES   = 8;
   // Field positions in the mode register
   localparam int CBR_POS_SW_EN   = 3;
   localparam int CBR_POS_SW_MODE = 1;
   localparam int CBR_POS_FREQ    = 0;
   localparam int CBR_POS_RB_MODE = 6;
   // Reset values
   localparam logic       CBR_SW_EN_RST   = 1'b0;
   localparam logic [1:0] CBR_SW_MODE_RST = 2'h3;
   localparam logic [7:0] CBR_GATE_RST    = 8'hff;
   localparam logic [4:0] CBR_COUNT_RST   = 5'h08;
   // PLL mode encoding, shared by readback and override pairs
   localparam logic [1:0] CBR_PLL_LO_BW  = 2'h0;
   localparam logic [1:0] CBR_PLL_BYPASS = 2'h1;
   localparam logic [1:0] CBR_PLL_HI_BW  = 2'h3;
   // Bit slots within one byte frame
   localparam logic [3:0] CBR_BIT_LAST = 4'h7;
   localparam logic [3:0] CBR_BIT_ACK  = 4'h8;
   // Register write request crossing from the link to the core clock
   typedef struct packed {
      logic [7:0] idx;
      logic [7:0] data;
   } cbr_wr_t;
   typedef enum logic [2:0] {
      CBR_ST_IDLE, CBR_ST_ADDR, CBR_ST_INDEX, CBR_ST_WCOUNT, CBR_ST_WDATA, CBR_ST_RCOUNT, CBR_ST_RDATA
   } cbr_st_t;
endpackage

// *** rtl/cbr_smbus_regs.sv ***
// SMBus target register bank for a differential clock buffer
// Operation
// R01 - Host sends start, write address, waits ack, sends index N, waits ack.
// R02 - Host repeats start and read address; device acks before sending data.
// R03 - First byte returned in a read is the byte count.
// R04 - Then bytes from index N upward, last one N plus count minus one.
// R05 - Host acks every returned byte except the last.
// R06 - Host ends read with not-ack then stop; device releases data line.
// R07 - Mode bits 7 and 6 read the strapped PLL mode, unaffected by override.
// R08 - Mode bit 3 picks strap or software PLL mode; resets to 0.
// R09 - With override set, bits 2 and 1 give the PLL mode; reset to 1.
// R10 - Mode bit 0 reads the frequency strap: 0 is 133MHz, 1 is 100MHz.
// R11 - System performs a warm reset after changing override bits.
// R12 - Gate bit 0 forces output low, 1 hands it to its enable pin.
// R13 - Bytes 3, 4 and all reserved bits read as zero.
// R14 - Byte 5 holds fixed revision code high nibble, maker code low nibble.
// R15 - Byte 6 holds a fixed eight-bit part code.
// R16 - Block write: address, index, count, data bytes; device acks each.
// R17 - Index 7 bits 4 to 0 set read count; default 8.
// R18 - Device answers only its own address, ignores read-only and reserved bits.
// R19 - PLL mode encoding: 00 low bandwidth, 01 bypass, 11 high bandwidth.
`timescale 1ns/1ns
`default_nettype none
module cbr_smbus_regs
   import cbr_pkg::*;
#(
   parameter logic [3:0] REV_CODE   = 4'h3,  // Arbitrary value
   parameter logic [3:0] MAKER_CODE = 4'h9,  // Arbitrary value
   parameter logic [7:0] PART_CODE  = 8'ha2  // Arbitrary value
) (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       scl,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   input  wire logic [1:0] pll_bw_strap,
   input  wire logic       freq_sel_strap,
   input  wire logic [7:0] out_en_pin_n,
   output logic [7:0]      diff_clock_out_en,
   output logic [1:0]      pll_mode_out,
   output logic            freq_sel_readback
);

   ////////////////////////////////////////////////////////////////////////
   // Core clock domain

   logic [1:0]  bw_s1, bw_s2;
   logic        fq_s1, fq_s2;
   logic [7:0]  oe_s1, oe_s2;
   logic        strap_done;
   logic [1:0]  strap_mode;
   logic        strap_freq;
   logic        sw_en;
   logic [1:0]  sw_mode;
   logic [7:0]  gate;
   logic [4:0]  count;
   logic        wtg_s1, wtg_s2, wtg_s3;
   logic        wr_tgl;
   cbr_wr_t     wr_q;
   logic [63:0] image;

   // Pin synchronisers
   always_ff @(posedge mclk) begin
      bw_s1 <= pll_bw_strap;
      bw_s2 <= bw_s1;
      fq_s1 <= freq_sel_strap;
      fq_s2 <= fq_s1;
      oe_s1 <= out_en_pin_n;
      oe_s2 <= oe_s1;
   end

   // R07 strap capture once
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         strap_done <= 1'b0;
         strap_mode <= CBR_PLL_LO_BW;
         strap_freq <= 1'b0;
      end else if (!strap_done) begin
         strap_done <= 1'b1;
         strap_mode <= bw_s2;
         strap_freq <= fq_s2;
      end
   end

   // Write request toggle from the link side
   always_ff @(posedge mclk) begin
      wtg_s1 <= wr_tgl;
      wtg_s2 <= wtg_s1;
      wtg_s3 <= wtg_s2;
   end
   wire wr_fire = wtg_s2 ^ wtg_s3;

   // R18 writable fields only, others dropped
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sw_en   <= CBR_SW_EN_RST;
         sw_mode <= CBR_SW_MODE_RST;
         gate    <= CBR_GATE_RST;
         count   <= CBR_COUNT_RST;
      end else if (wr_fire) begin
         case (wr_q.idx)
            CBR_IDX_MODE: begin
               sw_en   <= wr_q.data[CBR_POS_SW_EN];
               sw_mode <= wr_q.data[CBR_POS_SW_MODE +: 2];
            end
            CBR_IDX_GATE_LO: gate[5:0] <= {wr_q.data[7:4], wr_q.data[2:1]};
            CBR_IDX_GATE_HI: gate[7:6] <= {wr_q.data[2], wr_q.data[0]};
            CBR_IDX_COUNT:   count <= wr_q.data[4:0];
            default: ;
         endcase
      end
   end

   // R08 R09 R19 mode source select
   wire [1:0] mode_sel = sw_en ? sw_mode : strap_mode;
   // R12 gating with the active low pins
   wire [7:0] next_out_en = gate & ~oe_s2;

   // Registered outputs
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         diff_clock_out_en <= 8'h00;
         pll_mode_out      <= CBR_PLL_LO_BW;
         freq_sel_readback <= 1'b0;
      end else begin
         diff_clock_out_en <= next_out_en;
         pll_mode_out      <= mode_sel;
         freq_sel_readback <= strap_freq;
      end
   end

   // R07 R10 R13 R14 R15 R17 read image, reserved bits zero
   wire [7:0] img_mode = {strap_mode, 2'h0, sw_en, sw_mode, strap_freq};
   wire [7:0] img_glo  = {gate[5:2], 1'b0, gate[1:0], 1'b0};
   wire [7:0] img_ghi  = {5'h00, gate[7], 1'b0, gate[6]};
   assign image = {{3'h0, count}, PART_CODE, REV_CODE, MAKER_CODE, 8'h00, 8'h00, img_ghi, img_glo, img_mode};

   ////////////////////////////////////////////////////////////////////////
   // Link clock domain

   logic        lrst_s1, link_rst_n;
   logic [63:0] img_s1, img_s2;
   logic        start_armed, start_prev;
   logic [7:0]  shift;
   logic        host_ack;
   cbr_st_t     st, next_st;
   logic [3:0]  bit_cnt, next_cnt;
   logic [7:0]  ptr, next_ptr;
   logic [7:0]  tx, next_tx;
   logic        rd_dir, next_rd_dir;
   logic        next_oe_n;
   cbr_wr_t     next_wr;
   logic        next_tgl;

   // Byte fetch from the image, zero above the map
   function automatic logic [7:0] rd_byte(input logic [63:0] img, input logic [7:0] idx);
      rd_byte = (idx < CBR_NUM_BYTES) ? img[{idx[2:0], 3'h0} +: 8] : 8'h00;
   endfunction

   // Reset and quasi-static image synchronisers
   always_ff @(negedge scl) begin
      lrst_s1    <= rst_n;
      link_rst_n <= lrst_s1;
      img_s1     <= image;
      img_s2     <= img_s1;
   end

   // Start seen when data falls with the clock high
   always_ff @(negedge sda_in) begin
      start_armed <= scl;
   end
   wire start_now = start_armed & ~start_prev;

   // Receive shift and host acknowledge sampling
   always_ff @(posedge scl) begin
      if (bit_cnt < CBR_BIT_ACK) begin
         shift <= {shift[6:0], sda_in};
      end
      if (bit_cnt == CBR_BIT_ACK) begin
         host_ack <= ~sda_in;
      end
   end

   wire       byte_done = (bit_cnt == CBR_BIT_LAST);
   wire       ack_end   = (bit_cnt == CBR_BIT_ACK);
   wire       addr_hit  = (shift[7:1] == CBR_TARGET_ADDR);
   wire       sending   = (st == CBR_ST_RCOUNT) || (st == CBR_ST_RDATA);
   wire [2:0] tx_pos    = 3'(4'h6 - bit_cnt);

   // Frame sequencer
   always_comb begin
      next_st     = st;
      next_cnt    = ack_end ? 4'h0 : 4'(bit_cnt + 4'h1);
      next_ptr    = ptr;
      next_tx     = tx;
      next_rd_dir = rd_dir;
      next_oe_n   = 1'b1;
      next_wr     = wr_q;
      next_tgl    = wr_tgl;
      if (start_now) begin
         next_st  = CBR_ST_ADDR;
         next_cnt = 4'h0;
      end else begin
         unique case (st)
            CBR_ST_IDLE: next_cnt = 4'h0;
            CBR_ST_ADDR: begin
               // R18 R02 acknowledge own address only
               if (byte_done && addr_hit) begin
                  next_oe_n   = 1'b0;
                  next_rd_dir = shift[0];
               end else if (byte_done) begin
                  next_st = CBR_ST_IDLE;
               end
               // R03 count goes out first
               if (ack_end && rd_dir) begin
                  next_st   = CBR_ST_RCOUNT;
                  next_tx   = rd_byte(img_s2, CBR_IDX_COUNT);
                  next_oe_n = next_tx[7];
               end else if (ack_end) begin
                  next_st = CBR_ST_INDEX;
               end
            end
            CBR_ST_INDEX: begin
               if (byte_done) begin
                  next_ptr  = shift;
                  next_oe_n = 1'b0;
               end
               if (ack_end) next_st = CBR_ST_WCOUNT;
            end
            CBR_ST_WCOUNT: begin
               // R16 count byte acknowledged
               if (byte_done) next_oe_n = 1'b0;
               if (ack_end) next_st = CBR_ST_WDATA;
            end
            CBR_ST_WDATA: begin
               // R16 data byte stored and acknowledged
               if (byte_done) begin
                  next_oe_n = 1'b0;
                  next_wr   = '{idx: ptr, data: shift};
                  next_tgl  = ~wr_tgl;
                  next_ptr  = 8'(ptr + 8'h01);
               end
            end
            CBR_ST_RCOUNT, CBR_ST_RDATA: begin
               if (bit_cnt < CBR_BIT_LAST) next_oe_n = tx[tx_pos];
               // R04 R05 next byte on ack, R06 release on not-ack
               if (ack_end && host_ack) begin
                  next_st   = CBR_ST_RDATA;
                  next_tx   = rd_byte(img_s2, ptr);
                  next_ptr  = 8'(ptr + 8'h01);
                  next_oe_n = next_tx[7];
               end else if (ack_end) begin
                  next_st = CBR_ST_IDLE;
               end
            end
         endcase
      end
   end

   // Link state registers
   always_ff @(negedge scl) begin
      start_prev <= start_armed;
      if (!link_rst_n) begin
         st       <= CBR_ST_IDLE;
         bit_cnt  <= 4'h0;
         ptr      <= 8'h00;
         tx       <= 8'h00;
         rd_dir   <= 1'b0;
         sda_oe_n <= 1'b1;
         wr_q     <= '0;
         wr_tgl   <= 1'b0;
      end else begin
         st       <= next_st;
         bit_cnt  <= next_cnt;
         ptr      <= next_ptr;
         tx       <= next_tx;
         rd_dir   <= next_rd_dir;
         sda_oe_n <= next_oe_n;
         wr_q     <= next_wr;
         wr_tgl   <= next_tgl;
      end
   end

   // Open drain line only ever pulled low
   assign sda_out = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   AST_ADDR_MISS: assert property (@(negedge scl) disable iff (!link_rst_n) // R18
      (!start_now && st == CBR_ST_ADDR && byte_done && !addr_hit) |=> (st == CBR_ST_IDLE && sda_oe_n))
      else $error("foreign address was answered");
   AST_COUNT_FIRST: assert property (@(negedge scl) disable iff (!link_rst_n) // R03
      (!start_now && st == CBR_ST_ADDR && ack_end && rd_dir) |=> (st == CBR_ST_RCOUNT && tx == img_s2[63:56]))
      else $error("read did not start with the count");
   AST_INDEX_STEP: assert property (@(negedge scl) disable iff (!link_rst_n) // R04
      (!start_now && sending && ack_end && host_ack) |=> (ptr == 8'($past(ptr) + 8'h01) && st == CBR_ST_RDATA))
      else $error("read index did not advance");
   AST_NACK_RELEASE: assert property (@(negedge scl) disable iff (!link_rst_n) // R06
      (!start_now && sending && ack_end && !host_ack) |=> (sda_oe_n && st == CBR_ST_IDLE) ##1 sda_oe_n)
      else $error("data line held after not-ack");
   AST_STRAP_HOLD: assert property (@(posedge mclk) disable iff (!rst_n) // R07
      strap_done |=> $stable(strap_mode) && $stable(strap_freq))
      else $error("strap readback changed");
   AST_SW_RESET: assert property (@(posedge mclk) // R08
      !rst_n |=> (sw_en == CBR_SW_EN_RST && sw_mode == CBR_SW_MODE_RST && gate == CBR_GATE_RST))
      else $error("control reset value wrong");
   AST_MODE_OUT: assert property (@(posedge mclk) disable iff (!rst_n) // R09
      (sw_en && $stable(sw_mode)) |=> pll_mode_out == $past(sw_mode))
      else $error("override mode not applied");
   AST_GATE_LOW: assert property (@(posedge mclk) disable iff (!rst_n) // R12
      !gate[0] ##1 !gate[0] |-> !diff_clock_out_en[0])
      else $error("gated output still enabled");
   AST_COUNT_WRITE: assert property (@(posedge mclk) disable iff (!rst_n) // R17
      (wr_fire && wr_q.idx == CBR_IDX_COUNT) |=> count == $past(wr_q.data[4:0]))
      else $error("byte count not written");

endmodule
`default_nettype wire

// *** tb/cbr_host_model.sv ***
// SMBus host controller model driving the link clock and its side of the data line
`timescale 1ns/1ns
`default_nettype none
module cbr_host_model (
   output logic      scl,
   output logic      sda_h,
   input  wire logic sda_line
);
   // Clock stands high and data is released outside frames
   initial begin
      scl   = 1'b1;
      sda_h = 1'b1;
   end
   // One bit slot: data set while clock is low, line taken at the rising edge
   task automatic bit_io(input logic b, output logic r);
      #7 sda_h = b;
      #8 scl = 1'b1;
      r = sda_line;
      #15 scl = 1'b0;
   endtask
   // Idle clock pulses with data released, only used around reset
   task automatic idle(input int n);
      repeat (n) begin
         #15 scl = 1'b0;
         #15 scl = 1'b1;
      end
   endtask
   task automatic start();
      if (scl == 1'b0) begin
         #7 sda_h = 1'b1;
         #8 scl = 1'b1;
      end
      #15 sda_h = 1'b0;
      #15 scl = 1'b0;
   endtask
   task automatic stop();
      #7 sda_h = 1'b0;
      #8 scl = 1'b1;
      #15 sda_h = 1'b1;
      #15;
   endtask
   // one byte MSB first, then the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic ack_bit, output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(ack_bit, r);
      ack = ~r;
   endtask
endmodule
`default_nettype wire

// *** tb/cbr_smbus_regs_tb.sv ***
// Self-checking bench for the clock buffer SMBus register bank
`timescale 1ns/1ns
`default_nettype none
module cbr_smbus_regs_tb
   import cbr_pkg::*;
;
   localparam logic [3:0] REV   = 4'h6;   // Arbitrary value
   localparam logic [3:0] MAKER = 4'h2;   // Arbitrary value
   localparam logic [7:0] PART  = 8'h5c;  // Arbitrary value
   logic       mclk, rst_n, scl, sda_h, sda_line, sda_out, sda_oe_n;
   logic       freq_sel_strap, freq_sel_readback;
   logic [1:0] pll_bw_strap, pll_mode_out;
   logic [7:0] out_en_pin_n, diff_clock_out_en;
   logic [1:0] modes [3] = '{CBR_PLL_LO_BW, CBR_PLL_BYPASS, CBR_PLL_HI_BW};
   int         failures, check_count;
   // Open-drain data line with pull-up
   assign sda_line = sda_h & (sda_oe_n | sda_out);
   cbr_smbus_regs #(.REV_CODE(REV), .MAKER_CODE(MAKER), .PART_CODE(PART)) u_cbr_smbus_regs (
      .mclk(mclk), .rst_n(rst_n), .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .pll_bw_strap(pll_bw_strap), .freq_sel_strap(freq_sel_strap), .out_en_pin_n(out_en_pin_n),
      .diff_clock_out_en(diff_clock_out_en), .pll_mode_out(pll_mode_out), .freq_sel_readback(freq_sel_readback));
   cbr_host_model u_cbr_host_model (.scl(scl), .sda_h(sda_h), .sda_line(sda_line));
   // Core clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Reset with given straps; link side sees idle clock pulses meanwhile
   task automatic do_reset(input logic [1:0] bw, input logic fs);
      @(negedge mclk);
      rst_n = 1'b0;
      pll_bw_strap = bw;
      freq_sel_strap = fs;
      u_cbr_host_model.idle(4);
      repeat (16) @(negedge mclk);
      rst_n = 1'b1;
      u_cbr_host_model.idle(3);
      repeat (4) @(negedge mclk);
   endtask
   // Send one byte and expect the device to acknowledge it
   task automatic snd(input logic [7:0] b);
      logic [7:0] q;
      logic       a;
      u_cbr_host_model.xfer(b, 1'b1, q, a);
      chk("ack", {7'h00, a}, 8'h01);
   endtask
   task automatic wr(input logic [7:0] n, input int k, input logic [63:0] d);
      u_cbr_host_model.start();
      snd({CBR_TARGET_ADDR, 1'b0});
      snd(n);
      snd(8'(k));
      for (int i = 0; i < k; i++) snd(d[8*(k-1-i) +: 8]);
      u_cbr_host_model.stop();
      repeat (8) @(negedge mclk);
   endtask
   // Read k bytes, the count byte first, acking all but the last
   task automatic rd(input logic [7:0] n, input int k, input logic [79:0] e);
      logic [7:0] q;
      logic       a;
      u_cbr_host_model.start();
      snd({CBR_TARGET_ADDR, 1'b0});
      snd(n);
      u_cbr_host_model.start();
      snd({CBR_TARGET_ADDR, 1'b1});
      for (int i = 0; i < k; i++) begin
         u_cbr_host_model.xfer(8'hff, 1'(i == k - 1), q, a);
         chk("read byte", q, e[8*(k-1-i) +: 8]);
      end
      u_cbr_host_model.stop();
      chk("release", {7'h00, sda_oe_n}, 8'h01);
   endtask
   // Cut a hung run short
   initial begin
      #1000000;
      failures++;
      summarize();
   end
   // Main sequence
   initial begin
      logic [7:0] q;
      logic       a;
      failures = 0;
      check_count = 0;
      rst_n = 1'b0;
      out_en_pin_n = 8'h00;
      do_reset(CBR_PLL_BYPASS, 1'b1);
      chk("gates", diff_clock_out_en, 8'hff);
      chk("mode", {6'h00, pll_mode_out}, 8'h01);
      chk("freq", {7'h00, freq_sel_readback}, 8'h01);
      rd(8'h00, 10, {8'h08, 8'h47, 8'hf6, 8'h05, 8'h00, 8'h00, REV, MAKER, PART, 8'h08, 8'h00});
      // Foreign address is left unanswered
      u_cbr_host_model.start();
      u_cbr_host_model.xfer({CBR_TARGET_ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
      chk("foreign ack", {7'h00, a}, 8'h00);
      u_cbr_host_model.stop();
      // Software override through every mode, read-only bits written high
      for (int i = 0; i < 3; i++) begin
         wr(8'h00, 1, {56'h0, 5'h1f, modes[i], 1'b1});
         chk("override", {6'h00, pll_mode_out}, {6'h00, modes[i]});
         rd(8'h00, 2, {8'h08, 5'b01001, modes[i], 1'b1});
      end
      // Gates combined with the enable pins
      @(negedge mclk);
      out_en_pin_n = 8'h81;
      repeat (8) @(negedge mclk);
      chk("pins", diff_clock_out_en, 8'h7e);
      wr(8'h01, 2, {48'h0, 8'h00, 8'hff});
      chk("gates off", diff_clock_out_en, 8'h40);
      wr(8'h01, 1, {56'h0, 8'h2d});
      chk("gate map", diff_clock_out_en, 8'h4a);
      rd(8'h01, 3, {8'h08, 8'h24, 8'h05});
      // Reserved and fixed bytes ignore writes, count register narrows to five bits
      wr(8'h03, 5, {24'h0, 8'hff, 8'hff, 8'hff, 8'hff, 8'hc5});
      rd(8'h03, 6, {8'h05, 8'h00, 8'h00, REV, MAKER, PART, 8'h05});
      // Warm reset recaptures straps and restores defaults
      do_reset(CBR_PLL_HI_BW, 1'b0);
      chk("warm mode", {6'h00, pll_mode_out}, 8'h03);
      chk("warm freq", {7'h00, freq_sel_readback}, 8'h00);
      chk("warm gates", diff_clock_out_en, 8'h7e);
      rd(8'h00, 4, {8'h08, 8'hc6, 8'hf6, 8'h05});
      summarize();
   end
endmodule
`default_nettype wire
